// File: core/bbd_core.sv
// decode and timed execution of branch, bit, rotate, test and mask opcodes
// Behaviour
// - 0x22 higher, 0x23 lower-or-same, 2 bytes, 3 cycles
// - 0x24 carry clear, 0x25 carry set, 3 cycles
// - 0x28/0x29 branch on half-carry clear/set
// - 0x2C/0x2D branch on mask clear/set
// - 0x2E/0x2F branch on irq line low/high
// - bit-high branch opcode 2n, 3 bytes, 5 cycles
// - bit-low branch opcode 01+2n, 3 bytes, 5 cycles
// - bit set 10+2n, clear 11+2n, 5 cycles
// - rotate left opcodes 49/59/39/79/69, 3/3/5/5/6 cycles
// - rotate right 46/56/36/76/66, 3/3/5/5/6 cycles
// - test 4D/5D/3D/7D/6D, memory forms one cycle less
// - 9B sets, 9A clears mask, 2 cycles
//
// The Wishbone register port and the register offsets were decided locally.
module bbd_core
  import bbd_pkg::*;
(
  // clock, reset and enable
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // external interrupt line pin
  input  wire logic                    irq_line_i,
  // wishbone slave
  input  wire bbd_pkg::bbd_wb_req_type wb_req_i,
  output bbd_pkg::bbd_wb_rsp_type       wb_rsp_o,
  // execution status
  output logic                         busy_o,
  output logic                         done_o
);
  import bbd_pkg::*;

  typedef struct packed {
    bbd_state_type  st;
    logic [2:0]     irq_sync;
    logic           irq_lvl;
    logic [7:0]     op;
    logic [31:0]    opnd;
    logic [15:0]    pc;
    logic [4:0]     ccr;
    logic [3:0]     cnt;
    bbd_dec_type    dec;
    logic           done;
    logic           illegal;
    logic           taken;
    logic [15:0]    next_pc;
    logic [7:0]     res;
    bbd_wb_rsp_type rsp;
  } bbd_regs_type;

  bbd_regs_type q;
  bbd_regs_type d;

  // idle, mask set, fetch address and operands cleared
  localparam bbd_regs_type REGS_RST = '{
    st:       BBD_ST_IDLE,
    irq_sync: 3'h0,
    irq_lvl:  1'b0,
    op:       BBD_OP_RST,
    opnd:     32'h0000_0000,
    pc:       BBD_PC_RST,
    ccr:      BBD_CCR_RST,
    cnt:      4'h0,
    dec:      '{valid: 1'b0, cls: BBD_CLS_REL, cycles: 4'h0, bytes: 2'h0},
    done:     1'b0,
    illegal:  1'b0,
    taken:    1'b0,
    next_pc:  BBD_PC_RST,
    res:      8'h00,
    rsp:      '{ack: 1'b0, dat: 32'h0000_0000}
  };

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic bbd_dec_type decode(input logic [7:0] op);
    bbd_dec_type r;
    logic [3:0]  cyc;
    logic [1:0]  len;
    r = '{valid: 1'b0, cls: BBD_CLS_REL, cycles: BBD_CYC_REL, bytes: BBD_LEN_2};
    cyc = BBD_CYC_RMW_IN;
    len = BBD_LEN_1;
    unique case (op[7:4])
      BBD_HI_INHA, BBD_HI_INHX: begin
        cyc = BBD_CYC_RMW_IN;
        len = BBD_LEN_1;
      end
      BBD_HI_DIR: begin
        cyc = BBD_CYC_RMW_M;
        len = BBD_LEN_2;
      end
      BBD_HI_IX: begin
        cyc = BBD_CYC_RMW_M;
        len = BBD_LEN_1;
      end
      BBD_HI_IX1: begin
        cyc = BBD_CYC_RMW_X1;
        len = BBD_LEN_2;
      end
      default: begin
        cyc = BBD_CYC_RMW_IN;
        len = BBD_LEN_1;
      end
    endcase
    if (op[7:4] == BBD_HI_REL) begin
      r = '{valid: 1'b1, cls: BBD_CLS_REL, cycles: BBD_CYC_REL, bytes: BBD_LEN_2};
    end else if (op[7:4] == BBD_HI_BTB) begin
      r = '{valid: 1'b1, cls: BBD_CLS_BTB, cycles: BBD_CYC_BTB, bytes: BBD_LEN_3};
    end else if (op[7:4] == BBD_HI_BSC) begin
      r = '{valid: 1'b1, cls: BBD_CLS_BSC, cycles: BBD_CYC_BSC, bytes: BBD_LEN_2};
    end else if (op == BBD_OP_SEI || op == BBD_OP_CLI) begin
      r = '{valid: 1'b1, cls: BBD_CLS_MASK, cycles: BBD_CYC_MASK, bytes: BBD_LEN_1};
    end else if (op[7:4] inside {BBD_HI_INHA, BBD_HI_INHX, BBD_HI_DIR, BBD_HI_IX, BBD_HI_IX1}) begin
      if (op[3:0] == BBD_LO_ROL) begin
        r = '{valid: 1'b1, cls: BBD_CLS_ROL, cycles: cyc, bytes: len};
      end else if (op[3:0] == BBD_LO_ROR) begin
        r = '{valid: 1'b1, cls: BBD_CLS_ROR, cycles: cyc, bytes: len};
      end else if (op[3:0] == BBD_LO_TST) begin
        // memory forms skip the write-back cycle
        r = '{valid: 1'b1, cls: BBD_CLS_TST, cycles: cyc, bytes: len};
        if (cyc != BBD_CYC_RMW_IN) begin
          r.cycles = cyc - BBD_CYC_TST_RB;
        end
      end
    end
    return r;
  endfunction

  // condition for the relative group: op[3:1] picks, op[0] inverts
  function automatic logic rel_cond(input logic [7:0] op, input logic [4:0] ccr, input logic irq);
    logic c;
    unique case (op[3:1])
      3'h0: c = 1'b1;
      3'h1: c = ~(ccr[BBD_CCR_C] | ccr[BBD_CCR_Z]);
      3'h2: c = ~ccr[BBD_CCR_C];
      3'h3: c = ~ccr[BBD_CCR_Z];
      3'h4: c = ~ccr[BBD_CCR_H];
      3'h5: c = ~ccr[BBD_CCR_N];
      3'h6: c = ~ccr[BBD_CCR_I];
      3'h7: c = ~irq;
      default: c = 1'b0;
    endcase
    return op[0] ? ~c : c;
  endfunction

  logic        wb_hit;
  logic        start;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic [7:0]  data;
  logic [7:0]  offs;
  logic        bit_val;
  logic        tk;
  logic [15:0] seq_pc;

  always_comb begin
    d = q;
    wb_hit = wb_req_i.cyc & wb_req_i.stb & ~q.rsp.ack;
    start = 1'b0;
    wr_word = 32'h0000_0000;
    rd_word = 32'h0000_0000;
    data = q.opnd[23:16];
    offs = 8'h00;
    bit_val = 1'b0;
    tk = 1'b0;
    seq_pc = 16'h0000;

    // irq pin: three stages, level moves once stages two and three agree
    d.irq_sync = {q.irq_sync[1:0], irq_line_i};
    if (q.irq_sync[1] == q.irq_sync[2]) begin
      d.irq_lvl = q.irq_sync[2];
    end

    // wishbone: ack one cycle after the request, dropped the cycle after
    d.rsp.ack = wb_hit;
    unique case (wb_req_i.adr)
      BBD_OFS_CTRL:   rd_word = {23'h0, 1'b0, q.op};
      BBD_OFS_OPND:   rd_word = q.opnd;
      BBD_OFS_PC:     rd_word = {16'h0000, q.pc};
      BBD_OFS_CCR:    rd_word = {27'h0, q.ccr};
      BBD_OFS_STATUS: begin
        rd_word[BBD_STS_BUSY]        = (q.st == BBD_ST_EXEC);
        rd_word[BBD_STS_DONE]        = q.done;
        rd_word[BBD_STS_TAKEN]       = q.taken;
        rd_word[BBD_STS_ILLEGAL]     = q.illegal;
        rd_word[BBD_STS_BYTES +: 2]  = q.dec.bytes;
        rd_word[BBD_STS_CYCLES +: 4] = q.dec.cycles;
        rd_word[BBD_STS_IRQ]         = q.irq_lvl;
      end
      BBD_OFS_RESULT: begin
        rd_word[BBD_RES_PC +: 16]    = q.next_pc;
        rd_word[BBD_RES_BYTE +: 8]   = q.res;
      end
      default:        rd_word = 32'h0000_0000;
    endcase
    d.rsp.dat = wb_hit ? rd_word : q.rsp.dat;

    // software writes are refused while an instruction executes
    if (wb_hit && wb_req_i.we && q.st == BBD_ST_IDLE) begin
      unique case (wb_req_i.adr)
        BBD_OFS_CTRL: begin
          wr_word = merge({23'h0, 1'b0, q.op}, wb_req_i.dat, wb_req_i.sel);
          d.op = wr_word[7:0];
          start = wr_word[BBD_CTRL_START_BIT] & wb_req_i.sel[1];
        end
        BBD_OFS_OPND: d.opnd = merge(q.opnd, wb_req_i.dat, wb_req_i.sel);
        BBD_OFS_PC: begin
          wr_word = merge({16'h0000, q.pc}, wb_req_i.dat, wb_req_i.sel);
          d.pc = wr_word[15:0];
        end
        BBD_OFS_CCR: begin
          wr_word = merge({27'h0, q.ccr}, wb_req_i.dat, wb_req_i.sel);
          d.ccr = wr_word[4:0];
        end
        default: begin
        end
      endcase
    end

    unique case (q.st)
      BBD_ST_IDLE: begin
        if (start) begin
          d.dec = decode(d.op);
          d.done = 1'b0;
          d.taken = 1'b0;
          d.illegal = ~d.dec.valid;
          if (d.dec.valid) begin
            d.cnt = d.dec.cycles - 4'h1;
            d.st = BBD_ST_EXEC;
          end else begin
            d.done = 1'b1;
          end
        end
      end
      BBD_ST_EXEC: begin
        if (q.cnt != 4'h0) begin
          d.cnt = q.cnt - 4'h1;
        end else begin
          d.st = BBD_ST_IDLE;
          d.done = 1'b1;
          seq_pc = q.pc + {14'h0000, q.dec.bytes};
          d.next_pc = seq_pc;
          d.res = data;
          unique case (q.dec.cls)
            BBD_CLS_REL: begin
              tk = rel_cond(q.op, q.ccr, q.irq_lvl);
              offs = q.opnd[7:0];
            end
            BBD_CLS_BTB: begin
              // byte one holds the branch offset, data (byte two) holds what was read
              bit_val = data[q.op[3:1]];
              tk = q.op[0] ? ~bit_val : bit_val;
              offs = q.opnd[15:8];
              d.ccr[BBD_CCR_C] = bit_val;
            end
            BBD_CLS_BSC: d.res[q.op[3:1]] = ~q.op[0];
            BBD_CLS_ROL: begin
              d.res = {data[6:0], q.ccr[BBD_CCR_C]};
              d.ccr[BBD_CCR_C] = data[7];
            end
            BBD_CLS_ROR: begin
              d.res = {q.ccr[BBD_CCR_C], data[7:1]};
              d.ccr[BBD_CCR_C] = data[0];
            end
            BBD_CLS_TST: d.res = data;
            BBD_CLS_MASK: d.ccr[BBD_CCR_I] = (q.op == BBD_OP_SEI);
            default: begin
            end
          endcase
          if (q.dec.cls inside {BBD_CLS_ROL, BBD_CLS_ROR, BBD_CLS_TST}) begin
            d.ccr[BBD_CCR_N] = d.res[7];
            d.ccr[BBD_CCR_Z] = (d.res == 8'h00);
          end
          // cycle count already spent; only the target depends on the outcome
          d.taken = tk;
          if (tk) begin
            d.next_pc = seq_pc + {{8{offs[7]}}, offs};
          end
        end
      end
      default: d.st = BBD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q <= REGS_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign wb_rsp_o = q.rsp;
  assign busy_o   = q.st[1];
  assign done_o   = q.done;

endmodule

// File: core/bbd_pkg.sv
// package for the branch, bit and read-modify-write decode block
package bbd_pkg;

  // register word offsets on the wishbone bus
  localparam logic [7:0] BBD_OFS_CTRL   = 8'h00;
  localparam logic [7:0] BBD_OFS_OPND   = 8'h04;
  localparam logic [7:0] BBD_OFS_PC     = 8'h08;
  localparam logic [7:0] BBD_OFS_CCR    = 8'h0C;
  localparam logic [7:0] BBD_OFS_STATUS = 8'h10;
  localparam logic [7:0] BBD_OFS_RESULT = 8'h14;

  // control word fields
  localparam int BBD_CTRL_START_BIT = 8;

  // status and result word fields
  localparam int BBD_STS_BUSY    = 0;
  localparam int BBD_STS_DONE    = 1;
  localparam int BBD_STS_TAKEN   = 2;
  localparam int BBD_STS_ILLEGAL = 3;
  localparam int BBD_STS_BYTES   = 4;
  localparam int BBD_STS_CYCLES  = 8;
  localparam int BBD_STS_IRQ     = 12;
  localparam int BBD_RES_PC      = 0;
  localparam int BBD_RES_BYTE    = 16;

  // condition code bit positions
  localparam int BBD_CCR_C = 0;
  localparam int BBD_CCR_Z = 1;
  localparam int BBD_CCR_N = 2;
  localparam int BBD_CCR_I = 3;
  localparam int BBD_CCR_H = 4;

  // reset values
  localparam logic [4:0]  BBD_CCR_RST = 5'h08;
  localparam logic [7:0]  BBD_OP_RST  = 8'h9D;
  localparam logic [15:0] BBD_PC_RST  = 16'h0000;

  // opcodes and opcode groups
  localparam logic [3:0] BBD_HI_BTB   = 4'h0;
  localparam logic [3:0] BBD_HI_BSC   = 4'h1;
  localparam logic [3:0] BBD_HI_REL   = 4'h2;
  localparam logic [3:0] BBD_HI_DIR   = 4'h3;
  localparam logic [3:0] BBD_HI_INHA  = 4'h4;
  localparam logic [3:0] BBD_HI_INHX  = 4'h5;
  localparam logic [3:0] BBD_HI_IX1   = 4'h6;
  localparam logic [3:0] BBD_HI_IX    = 4'h7;
  localparam logic [3:0] BBD_LO_ROL   = 4'h9;
  localparam logic [3:0] BBD_LO_ROR   = 4'h6;
  localparam logic [3:0] BBD_LO_TST   = 4'hD;
  localparam logic [7:0] BBD_OP_SEI   = 8'h9B;
  localparam logic [7:0] BBD_OP_CLI   = 8'h9A;

  // cycle counts
  localparam logic [3:0] BBD_CYC_REL    = 4'h3;
  localparam logic [3:0] BBD_CYC_BTB    = 4'h5;
  localparam logic [3:0] BBD_CYC_BSC    = 4'h5;
  localparam logic [3:0] BBD_CYC_RMW_IN = 4'h3;
  localparam logic [3:0] BBD_CYC_RMW_M  = 4'h5;
  localparam logic [3:0] BBD_CYC_RMW_X1 = 4'h6;
  localparam logic [3:0] BBD_CYC_MASK   = 4'h2;
  localparam logic [3:0] BBD_CYC_TST_RB = 4'h1;

  // byte counts
  localparam logic [1:0] BBD_LEN_1 = 2'h1;
  localparam logic [1:0] BBD_LEN_2 = 2'h2;
  localparam logic [1:0] BBD_LEN_3 = 2'h3;

  typedef enum logic [2:0] {
    BBD_CLS_REL  = 3'h0,
    BBD_CLS_BTB  = 3'h1,
    BBD_CLS_BSC  = 3'h2,
    BBD_CLS_ROL  = 3'h3,
    BBD_CLS_ROR  = 3'h4,
    BBD_CLS_TST  = 3'h5,
    BBD_CLS_MASK = 3'h6
  } bbd_cls_type;

  typedef enum logic [1:0] {
    BBD_ST_IDLE = 2'b01,
    BBD_ST_EXEC = 2'b10
  } bbd_state_type;

  typedef struct packed {
    logic        valid;
    bbd_cls_type cls;
    logic [3:0]  cycles;
    logic [1:0]  bytes;
  } bbd_dec_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } bbd_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } bbd_wb_rsp_type;

endpackage

// File: test/bbd_prog_rom.sv
// program memory model holding the opcode stream under test
module bbd_prog_rom (
  // fetch address
  input  wire logic [5:0] addr_i,
  // opcode byte
  output logic      [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] TAIL [27] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h28, 8'h29, 8'h2C, 8'h2D, 8'h2E,
    8'h2F, 8'h49, 8'h59, 8'h39, 8'h79, 8'h69, 8'h46, 8'h56, 8'h36, 8'h76, 8'h66, 8'h4D, 8'h5D,
    8'h3D, 8'h7D, 8'h6D, 8'h9B, 8'h9A};
  logic [7:0] mem [64];
  // first 32 bytes are every bit branch and bit set/clear form
  initial begin
    for (int i = 0; i < 64; i++) begin
      if (i < 32) mem[i] = i[7:0];
      else if (i < 59) mem[i] = TAIL[i-32];
      else mem[i] = 8'h9D;
    end
  end
  assign byte_o = mem[addr_i];
endmodule

// File: test/bbd_core_checker.sv
// timing checks on the decode core ports
module bbd_core_checker
  import bbd_pkg::*;
(
  input wire logic                    clk_sys_i,
  input wire logic                    rst_i,
  input wire logic                    ce_i,
  input wire logic                    irq_line_i,
  input wire bbd_pkg::bbd_wb_req_type wb_req_i,
  input wire bbd_pkg::bbd_wb_rsp_type wb_rsp_o,
  input wire logic                    busy_o,
  input wire logic                    done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       st;
  logic [7:0] op;
  assign op = wb_req_i.dat[7:0];
  assign st = ce_i && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_rsp_o.ack && !busy_o
              && wb_req_i.adr == 8'h00 && (&wb_req_i.sel[1:0]) && wb_req_i.dat[8];
  default clocking cb @(posedge clk_sys_i); endclocking
  // a frozen clock enable stretches every count, so those attempts are dropped
  default disable iff (rst_i || !ce_i);
  sequence s_fin;
    !busy_o && done_o;
  endsequence
  a_rel_three: assert property (st && op[7:4] == 4'h2 |=> busy_o [*3] ##1 s_fin)
    else $error("relative branch timing");
  a_btb_five: assert property (st && op[7:4] == 4'h0 |=> busy_o [*5] ##1 s_fin)
    else $error("bit branch timing");
  a_bsc_five: assert property (st && op[7:4] == 4'h1 |=> busy_o [*5] ##1 s_fin)
    else $error("bit set clear timing");
  a_rmw_inh_three: assert property (st && op inside {8'h49, 8'h59, 8'h46, 8'h56, 8'h4D, 8'h5D} |=> busy_o [*3] ##1 s_fin)
    else $error("inherent rmw timing");
  a_rmw_mem_five: assert property (st && op inside {8'h39, 8'h79, 8'h36, 8'h76} |=> busy_o [*5] ##1 s_fin)
    else $error("memory rmw timing");
  a_rmw_ix1_six: assert property (st && op inside {8'h69, 8'h66} |=> busy_o [*6] ##1 s_fin)
    else $error("offset rmw timing");
  a_tst_mem_four: assert property (st && op inside {8'h3D, 8'h7D} |=> (busy_o throughout ##3 1'b1) ##1 s_fin)
    else $error("memory test timing");
  a_tst_ix1_five: assert property (st && op == 8'h6D |=> busy_o [*5] ##1 s_fin)
    else $error("offset test timing");
  a_mask_two: assert property (st && op[7:1] == 7'h4D |=> busy_o ##1 busy_o ##1 s_fin)
    else $error("mask op timing");
endmodule

bind bbd_core bbd_core_checker chk_u (
  .clk_sys_i  (clk_sys_i),
  .rst_i      (rst_i),
  .ce_i       (ce_i),
  .irq_line_i (irq_line_i),
  .wb_req_i   (wb_req_i),
  .wb_rsp_o   (wb_rsp_o),
  .busy_o     (busy_o),
  .done_o     (done_o)
);

// File: test/testbench.sv
// self-checking bench for the decode core
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bbd_pkg::*;
  logic           clk_sys_i;
  logic           rst_i;
  logic           irq;
  logic           ce;
  logic           busy_o;
  logic           done_o;
  logic [5:0]     rom_addr;
  logic [7:0]     rom_byte;
  logic [31:0]    bcnt = 32'h0000_0000;
  int             errors;
  int             compares;
  bbd_wb_req_type req;
  bbd_wb_rsp_type rsp;

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // clock enable driven so that a freeze can be exercised
  bbd_core dut_u (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .ce_i       (ce),
    .irq_line_i (irq),
    .wb_req_i   (req),
    .wb_rsp_o   (rsp),
    .busy_o     (busy_o),
    .done_o     (done_o)
  );
  bbd_prog_rom rom_u (
    .addr_i (rom_addr),
    .byte_o (rom_byte)
  );

  always @(posedge clk_sys_i) if (busy_o === 1'b1) bcnt <= bcnt + 1;

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    req <= '{1'b1, 1'b1, we, a, 4'hF, d};
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    if (rsp.ack !== 1'b1) errors++;
    q = rsp.dat;
    req <= '0;
    @(posedge clk_sys_i);
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic model(input logic [7:0] op, input logic [4:0] f, input logic [7:0] d, output logic [3:0] cy,
                       output logic [1:0] ln, output logic tk, output logic [7:0] r, output logic [4:0] fo,
                       output logic rc);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = op[7:4];
    lo = op[3:0];
    tk = 1'b0;
    r = d;
    fo = f;
    rc = 1'b1;
    case (hi)
      4'h0: begin
        cy = 4'h5; ln = 2'h3; rc = 1'b0; fo[0] = d[lo[3:1]]; tk = fo[0] ^ lo[0];
      end
      4'h1: begin
        cy = 4'h5; ln = 2'h2; r[lo[3:1]] = ~lo[0];
      end
      4'h2: begin
        cy = 4'h3; ln = 2'h2; rc = 1'b0;
        case (lo[3:1])
          3'h1: tk = f[0] | f[1];
          3'h4: tk = f[4];
          3'h6: tk = f[3];
          default: tk = f[0];
        endcase
        tk = tk ^ ~lo[0];
      end
      4'h9: begin
        cy = 4'h2; ln = 2'h1; rc = 1'b0; fo[3] = lo[0];
      end
      default: begin
        ln = (hi == 4'h3 || hi == 4'h6) ? 2'h2 : 2'h1;
        cy = (hi == 4'h6) ? 4'h6 : (hi[3:1] == 3'h2) ? 4'h3 : 4'h5;
        if (lo == 4'hD) begin
          rc = 1'b0;
          if (cy > 4'h3) cy = cy - 4'h1;
        end else if (lo == 4'h9) begin
          r = {d[6:0], f[0]}; fo[0] = d[7];
        end else begin
          r = {f[0], d[7:1]}; fo[0] = d[0];
        end
        fo[2] = r[7];
        fo[1] = (r == 8'h00);
      end
    endcase
  endtask

  task automatic run(input logic [7:0] op, input logic [4:0] f);
    logic [7:0]  d;
    logic [7:0]  r;
    logic [3:0]  cy;
    logic [1:0]  ln;
    logic        tk;
    logic        rc;
    logic [4:0]  fo;
    logic [15:0] np;
    logic [31:0] q;
    logic [31:0] b0;
    int          n;
    d = 8'hA5 ^ {8{f[0]}};
    model(op, f, d, cy, ln, tk, r, fo, rc);
    np = 16'h1234 + {14'h0, ln} + (tk ? 16'hFFF0 : 16'h0000);
    irq <= f[0];
    bus(1'b1, 8'h0C, {27'h0, f}, q);
    bus(1'b1, 8'h08, 32'h0000_1234, q);
    bus(1'b1, 8'h04, {8'h00, d, 8'hF0, 8'hF0}, q);
    b0 = bcnt;
    bus(1'b1, 8'h00, {23'h0, 1'b1, op}, q);
    n = 0;
    while (done_o !== 1'b1 && n < 20) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (done_o !== 1'b1) errors++;
    bus(1'b0, 8'h10, 32'h0, q);
    chk("status", {19'h0, f[0], cy, 2'b00, ln, 1'b0, tk, 2'b10}, q);
    chk("busy cycles", {28'h0, cy}, bcnt - b0);
    bus(1'b0, 8'h14, 32'h0, q);
    chk("next pc", {16'h0, np}, {16'h0, q[15:0]});
    if (rc) chk("result", {24'h0, r}, {24'h0, q[23:16]});
    bus(1'b0, 8'h0C, 32'h0, q);
    chk("ccr", {27'h0, fo}, q);
  endtask

  initial begin
    logic [31:0] q;
    logic [31:0] b0;
    int          n;
    rst_i = 1'b1;
    ce = 1'b1;
    irq = 1'b0;
    req = '0;
    rom_addr = '0;
    errors = 0;
    compares = 0;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    bus(1'b0, 8'h0C, 32'h0, q);
    chk("ccr reset", 32'h0000_0008, q);
    bus(1'b0, 8'h10, 32'h0, q);
    chk("status reset", 32'h0000_0000, q);
    bus(1'b0, 8'h1C, 32'h0, q);
    chk("unmapped", 32'h0000_0000, q);
    for (int i = 0; i < 59; i++) begin
      rom_addr <= i[5:0];
      @(posedge clk_sys_i);
      run(rom_byte, 5'h00);
      run(rom_byte, 5'h1F);
    end
    // unknown code: flagged and finished at once, never busy
    bus(1'b1, 8'h00, 32'h0000_0142, q);
    bus(1'b0, 8'h10, 32'h0, q);
    chk("illegal status", 32'h0000_000A, {28'h0, q[3:0]});
    // six-cycle rotate frozen for four edges must stay busy four edges longer
    b0 = bcnt;
    bus(1'b1, 8'h00, 32'h0000_0169, q);
    ce <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk("frozen state", 32'h0000_0001, {30'h0, done_o, busy_o});
    ce <= 1'b1;
    n = 0;
    while (done_o !== 1'b1 && n < 20) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (done_o !== 1'b1) errors++;
    chk("frozen busy cycles", {28'h0, BBD_CYC_RMW_X1} + 32'h0000_0004, bcnt - b0);
    // reset in mid-instruction: idle again, mask set again
    bus(1'b1, 8'h00, 32'h0000_0169, q);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("reset idle", 32'h0000_0000, {30'h0, done_o, busy_o});
    bus(1'b0, 8'h0C, 32'h0, q);
    chk("ccr reset again", {27'h0, BBD_CCR_RST}, q);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    give_verdict();
  end
endmodule
